// ==== design/hpc_pkg.sv ====
package hpc_pkg;
	// ==========================================
	// Core-side register addresses
	localparam logic [15:0] HPC_ADDR_CTRL  = 16'hffc2;
	localparam logic [15:0] HPC_ADDR_STAT  = 16'hffc3;
	localparam logic [15:0] HPC_ADDR_PCTRL = 16'hffc4;
	localparam logic [15:0] HPC_ADDR_BASE  = 16'hffc5;
	localparam logic [15:0] HPC_ADDR_RX    = 16'hffc6;
	localparam logic [15:0] HPC_ADDR_TX    = 16'hffc7;
	localparam logic [15:0] HPC_ADDR_DIR   = 16'hffc8;
	localparam logic [15:0] HPC_ADDR_VAL   = 16'hffc9;

	// ==========================================
	// Values after reset
	localparam logic [15:0] HPC_CTRL_RST  = 16'h0000;
	localparam logic [15:0] HPC_PCTRL_RST = 16'h0000;
	localparam logic [15:0] HPC_DIR_RST   = 16'h0000;
	localparam logic [7:0]  HPC_BASE_RST  = 8'h80;
	localparam logic [15:0] HPC_WORD_RST  = 16'h0000;

	// ==========================================
	// Field positions
	localparam int HPC_CTRL_RIE   = 0;
	localparam int HPC_CTRL_TIE   = 1;
	localparam int HPC_PCTRL_EN   = 6;
	localparam int HPC_PCTRL_MUX  = 11;
	localparam int HPC_STAT_RXF   = 0;
	localparam int HPC_STAT_TXE   = 1;
	localparam int HPC_STAT_CMD   = 2;
	localparam int HPC_STAT_HF0   = 3;
	localparam int HPC_STAT_HF1   = 4;
	localparam int HPC_ADDR_LO    = 3;
	localparam int HPC_ADDR_HI    = 10;

	// ==========================================
	// Data path sizes
	localparam int HPC_WORD_W     = 16;
	localparam int HPC_FIFO_DEPTH = 16;
endpackage

// ==== design/hpc_fifo.sv ====
`timescale 1ns/1ps
module hpc_fifo
	import hpc_pkg::*;
#(
	parameter int W = HPC_WORD_W,
	parameter int D = HPC_FIFO_DEPTH
)
(
	input  wire logic         i_clk_sys,
	input  wire logic         i_arst_n,
	input  wire logic         i_clr,
	input  wire logic         i_in_valid,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_in_ready,
	output logic              o_out_valid,
	output logic [W-1:0]      o_out_data,
	input  wire logic         i_out_ready
);
	localparam int AW = $clog2(D);

	logic [W-1:0]  mem [D];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0]   cnt_q;
	logic [AW:0]   cnt_d;
	wire           push = i_in_valid & o_in_ready;
	wire           pop  = o_out_valid & i_out_ready;

	// Occupancy; depth is a power of two so pointers wrap by themselves
	assign cnt_d = i_clr ? '0 : (cnt_q + (AW+1)'(push) - (AW+1)'(pop));
	assign o_out_data = mem[rd_ptr_q];

	// Storage has no reset, only the pointers, count and flags need one
	always_ff @(posedge i_clk_sys)
	begin
		if (push)
			mem[wr_ptr_q] <= i_in_data;
	end

	// Pointers and registered full/empty flags
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			wr_ptr_q    <= '0;
			rd_ptr_q    <= '0;
			cnt_q       <= '0;
			o_in_ready  <= 1'b1;
			o_out_valid <= 1'b0;
		end
		else
		begin
			wr_ptr_q    <= i_clr ? '0 : wr_ptr_q + AW'(push);
			rd_ptr_q    <= i_clr ? '0 : rd_ptr_q + AW'(pop);
			cnt_q       <= cnt_d;
			o_in_ready  <= cnt_d != (AW+1)'(D);
			o_out_valid <= cnt_d != '0;
		end
	end
endmodule

// ==== design/hpc_core.sv ====
// What this block does
// - Direction bit 1 makes its GPIO pin an output, 0 an input.
// - With the port enabled, pins still in GPIO use follow the direction register.
// - Input GPIO pin: value bit is read-only and returns the sampled pin level.
// - Output GPIO pin: value bit is read/write, reads back, drives the pin.
// - Non-GPIO pin: value bit reads nothing when input, stores writes when output.
// - Only the core reaches the pin value register; the host never touches it.
// - In multiplexed mode, chip select asserts only when latched address matches base.
// - Base register holds bits 7..0; bits 15..8 read zero.
// - Host word moves into core receive when one is buffered and receive-full clear, then receive-full sets.
// - Receive word valid while receive-full set; core read clears the flag.
// - Receive interrupt requested while enabled and receive-full set.
// - Transmit register is write-only; a write clears transmit-empty.
// - Transmit interrupt requested while enabled and transmit-empty set.
// - Core word copies to host receive pair when both flags clear, then both set.
// - Clearing the enable resets flags and data, keeping control, direction, base.
// - Hardware and software reset clear controls, base to 80h, flags to defaults.
// - Stop reset acts on flags and data only, like the individual reset.
// - With the port disabled every pin is GPIO under direction and value.
`timescale 1ns/1ps
module hpc_core
	import hpc_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_arst_n,
	input  wire logic        i_sw_reset,
	input  wire logic        i_stop_reset,
	input  wire logic [15:0] i_core_addr,
	input  wire logic        i_core_wr,
	input  wire logic        i_core_rd,
	input  wire logic [15:0] i_core_wdata,
	output logic      [15:0] o_core_rdata,
	output logic             o_rx_irq,
	output logic             o_tx_irq,
	input  wire logic [15:0] i_pin_in,
	output logic      [15:0] o_pin_out,
	output logic      [15:0] o_pin_oe,
	input  wire logic [15:0] i_pin_host_use,
	input  wire logic [10:0] i_host_addr,
	input  wire logic        i_host_cs,
	output logic             o_host_sel,
	input  wire logic        i_host_tx_valid,
	input  wire logic [15:0] i_host_tx_word,
	output logic             o_host_tx_ready,
	output logic             o_host_tx_pending,
	output logic      [15:0] o_host_rx_word,
	output logic             o_host_rx_full,
	input  wire logic        i_host_rx_ack,
	input  wire logic        i_host_cmd,
	input  wire logic        i_cmd_ack,
	input  wire logic [1:0]  i_host_flags
);
	// ==========================================
	// State
	logic [15:0] ctrl_q, pctrl_q, dir_q, val_q, rx_word_q, tx_word_q, rdata_d;
	logic [7:0]  base_q;
	logic        rx_full_q, tx_empty_q, cmd_q;
	logic [1:0]  hflag_q;
	logic [15:0] fifo_data;
	logic        fifo_valid;

	// ==========================================
	// Core register decode
	wire sel_ctrl  = i_core_addr == HPC_ADDR_CTRL;
	wire sel_stat  = i_core_addr == HPC_ADDR_STAT;
	wire sel_pctrl = i_core_addr == HPC_ADDR_PCTRL;
	wire sel_base  = i_core_addr == HPC_ADDR_BASE;
	wire sel_rx    = i_core_addr == HPC_ADDR_RX;
	wire sel_tx    = i_core_addr == HPC_ADDR_TX;
	wire sel_dir   = i_core_addr == HPC_ADDR_DIR;
	wire sel_val   = i_core_addr == HPC_ADDR_VAL;
	wire wr_pctrl  = i_core_wr & sel_pctrl;
	wire wr_val    = i_core_wr & sel_val;
	wire wr_tx     = i_core_wr & sel_tx;
	wire rd_rx     = i_core_rd & sel_rx;

	// ==========================================
	// Pin use and reset classes
	wire        port_enable_bit      = pctrl_q[HPC_PCTRL_EN];
	wire        mux      = pctrl_q[HPC_PCTRL_MUX];
	wire [15:0] gpio_w   = ~({16{port_enable_bit}} & i_pin_host_use);
	// Enable falling by a core write is the individual reset
	wire        hen_fall = wr_pctrl & port_enable_bit & ~i_core_wdata[HPC_PCTRL_EN];
	wire        flag_rst = i_sw_reset | i_stop_reset | hen_fall;

	// ==========================================
	// Transfers; each fires only when its destination flag is clear
	wire h2c_go = fifo_valid & ~rx_full_q;
	wire c2h_go = ~tx_empty_q & ~o_host_rx_full;

	// Pin value readback: inputs see the pin, non-GPIO inputs read zero
	wire [15:0] val_rd = (dir_q & val_q) | (~dir_q & gpio_w & i_pin_in);
	// Writes land only in bits whose direction is output
	wire [15:0] val_d  = (dir_q & i_core_wdata) | (~dir_q & val_q);
	wire [15:0] stat_w = {11'h000, hflag_q, cmd_q, tx_empty_q, rx_full_q};
	wire        addr_hit = i_host_addr[HPC_ADDR_HI:HPC_ADDR_LO] == base_q;

	// Read multiplexer; unmapped and write-only addresses read zero
	always_comb
	begin
		rdata_d = 16'h0000;
		case (1'b1)
			sel_ctrl:  rdata_d = ctrl_q;
			sel_stat:  rdata_d = stat_w;
			sel_pctrl: rdata_d = pctrl_q;
			sel_base:  rdata_d = {8'h00, base_q};
			sel_rx:    rdata_d = rx_word_q;
			sel_dir:   rdata_d = dir_q;
			sel_val:   rdata_d = val_rd;
			default:   rdata_d = 16'h0000;
		endcase
	end

	// ==========================================
	// Host-to-core buffer; the core side stalls it while receive is full
	hpc_fifo #(
		.W (HPC_WORD_W),
		.D (HPC_FIFO_DEPTH)
	) u_fifo (
		.i_clk_sys   (i_clk_sys),
		.i_arst_n    (i_arst_n),
		.i_clr       (flag_rst),
		.i_in_valid  (i_host_tx_valid),
		.i_in_data   (i_host_tx_word),
		.o_in_ready  (o_host_tx_ready),
		.o_out_valid (fifo_valid),
		.o_out_data  (fifo_data),
		.i_out_ready (h2c_go)
	);
	assign o_host_tx_pending = fifo_valid;

	// Configuration: cleared by hardware or software reset only
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			ctrl_q  <= HPC_CTRL_RST;
			pctrl_q <= HPC_PCTRL_RST;
			dir_q   <= HPC_DIR_RST;
			base_q  <= HPC_BASE_RST;
			hflag_q <= 2'b00;
		end
		else if (i_sw_reset)
		begin
			ctrl_q  <= HPC_CTRL_RST;
			pctrl_q <= HPC_PCTRL_RST;
			dir_q   <= HPC_DIR_RST;
			base_q  <= HPC_BASE_RST;
			hflag_q <= 2'b00;
		end
		else
		begin
			ctrl_q  <= (i_core_wr & sel_ctrl) ? i_core_wdata : ctrl_q;
			pctrl_q <= wr_pctrl ? i_core_wdata : pctrl_q;
			dir_q   <= (i_core_wr & sel_dir) ? i_core_wdata : dir_q;
			base_q  <= (i_core_wr & sel_base) ? i_core_wdata[7:0] : base_q;
			hflag_q <= i_host_flags;
		end
	end

	// Pin value is cleared by hardware reset only and keeps its content across the others; only the core writes it
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			val_q <= 16'h0000;
		else if (wr_val)
			val_q <= val_d;
	end

	// Flags: a hardware set beats a clear in the same cycle
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			rx_full_q      <= 1'b0;
			tx_empty_q     <= 1'b1;
			cmd_q          <= 1'b0;
			o_host_rx_full <= 1'b0;
		end
		else if (flag_rst)
		begin
			rx_full_q      <= 1'b0;
			tx_empty_q     <= 1'b1;
			cmd_q          <= 1'b0;
			o_host_rx_full <= 1'b0;
		end
		else
		begin
			rx_full_q      <= h2c_go | (rx_full_q & ~rd_rx);
			// A write racing a transfer loses; software must wait for empty
			tx_empty_q     <= c2h_go | (tx_empty_q & ~wr_tx);
			cmd_q          <= i_host_cmd | (cmd_q & ~i_cmd_ack);
			o_host_rx_full <= c2h_go | (o_host_rx_full & ~i_host_rx_ack);
		end
	end

	// Data words; the resets empty them
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			rx_word_q      <= HPC_WORD_RST;
			tx_word_q      <= HPC_WORD_RST;
			o_host_rx_word <= HPC_WORD_RST;
		end
		else if (flag_rst)
		begin
			rx_word_q      <= HPC_WORD_RST;
			tx_word_q      <= HPC_WORD_RST;
			o_host_rx_word <= HPC_WORD_RST;
		end
		else
		begin
			rx_word_q      <= h2c_go ? fifo_data : rx_word_q;
			tx_word_q      <= wr_tx ? i_core_wdata : tx_word_q;
			o_host_rx_word <= c2h_go ? tx_word_q : o_host_rx_word;
		end
	end

	// Registered outputs: read data, pins, requests, chip select
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_core_rdata <= 16'h0000;
			o_pin_out    <= 16'h0000;
			o_pin_oe     <= 16'h0000;
			o_rx_irq     <= 1'b0;
			o_tx_irq     <= 1'b0;
			o_host_sel   <= 1'b0;
		end
		else
		begin
			o_core_rdata <= i_core_rd ? rdata_d : o_core_rdata;
			o_pin_out    <= val_q;
			o_pin_oe     <= gpio_w & dir_q;
			o_rx_irq     <= ctrl_q[HPC_CTRL_RIE] & rx_full_q;
			o_tx_irq     <= ctrl_q[HPC_CTRL_TIE] & tx_empty_q;
			// Non-multiplexed mode passes the external select through
			o_host_sel   <= port_enable_bit & (mux ? addr_hit : i_host_cs);
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);

	a_pin_oe_dir: assert property (!port_enable_bit && dir_q[0] |=> o_pin_oe[0])
		else $error("output-direction GPIO pin not enabled");
	a_host_use_off: assert property (port_enable_bit && i_pin_host_use[1] |=> !o_pin_oe[1])
		else $error("host-owned pin driven as GPIO");
	a_input_read: assert property (i_core_rd && sel_val && dir_q == 16'h0000 && !port_enable_bit
		|=> o_core_rdata == $past(i_pin_in))
		else $error("input pin level not returned");
	a_val_drive: assert property (wr_val && !i_sw_reset ##1 1
		|=> o_pin_out == (($past(i_core_wdata, 2) & $past(dir_q, 2)) | ($past(val_q, 2) & ~$past(dir_q, 2))))
		else $error("written value not driven");
	a_val_hold: assert property (!wr_val |=> val_q == $past(val_q))
		else $error("pin value changed without core write");
	a_base_sel: assert property (port_enable_bit && mux && addr_hit |=> o_host_sel)
		else $error("matching address did not select");
	a_base_miss: assert property (mux && !addr_hit |=> !o_host_sel)
		else $error("select without address match");
	a_base_upper: assert property (i_core_rd && sel_base |=> o_core_rdata[15:8] == 8'h00)
		else $error("reserved base bits not zero");
	a_rx_move: assert property (h2c_go && !flag_rst |=> rx_full_q && rx_word_q == $past(fifo_data))
		else $error("host word not moved to receive");
	a_rx_clear: assert property (rd_rx && !h2c_go && !flag_rst |=> !rx_full_q)
		else $error("receive read did not clear full");
	a_rx_irq: assert property (ctrl_q[HPC_CTRL_RIE] && rx_full_q |=> o_rx_irq)
		else $error("receive interrupt missing");
	a_tx_clear: assert property (wr_tx && !c2h_go && !flag_rst |=> !tx_empty_q ##1 !o_tx_irq)
		else $error("transmit write did not clear empty");
	a_tx_irq: assert property (ctrl_q[HPC_CTRL_TIE] && tx_empty_q |=> o_tx_irq)
		else $error("transmit interrupt missing");
	a_tx_move: assert property (c2h_go && !flag_rst
		|=> o_host_rx_full && tx_empty_q && o_host_rx_word == $past(tx_word_q))
		else $error("core word not copied to host");
	a_indiv_rst: assert property (hen_fall && !i_sw_reset |=> tx_empty_q && !rx_full_q && !cmd_q
		&& dir_q == $past(dir_q) && base_q == $past(base_q))
		else $error("individual reset wrong");
	a_stop_rst: assert property (i_stop_reset && !i_sw_reset && !i_core_wr
		|=> tx_empty_q && !o_host_rx_full && ctrl_q == $past(ctrl_q))
		else $error("stop reset wrong");
	a_sw_rst: assert property (i_sw_reset |=> base_q == HPC_BASE_RST && dir_q == HPC_DIR_RST
		&& pctrl_q == HPC_PCTRL_RST && tx_empty_q)
		else $error("software reset wrong");

	// Disabled port and held words: nothing may leak out without a cause
	a_sel_off: assert property (!port_enable_bit |=> !o_host_sel)
		else $error("select while port disabled");
	a_oe_disabled: assert property (!port_enable_bit |=> o_pin_oe == $past(dir_q))
		else $error("disabled port pins not under direction");
	a_val_nongpio: assert property (i_core_rd && sel_val |=> (o_core_rdata & ~$past(dir_q) & ~$past(gpio_w)) == 16'h0000)
		else $error("host-owned input value bit not zero");
	a_rx_irq_off: assert property (!ctrl_q[HPC_CTRL_RIE] |=> !o_rx_irq)
		else $error("receive interrupt while disabled");
	a_rx_word_hold: assert property (rx_full_q && !flag_rst |=> rx_word_q == $past(rx_word_q))
		else $error("receive word changed while full");

	c_h2c: cover property (h2c_go ##[1:4] rd_rx);
	c_c2h: cover property (wr_tx ##[1:4] c2h_go);
	c_fifo_full: cover property (!o_host_tx_ready);
	c_indiv: cover property (hen_fall);
endmodule

// ==== tb/hpc_host_model.sv ====
`timescale 1ns/1ps
// ==========================================
// Host processor model: offers words, reads the receive pair
module hpc_host_model
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_tx_ready,
	input  wire logic        i_rx_full,
	input  wire logic [15:0] i_rx_word,
	input  wire logic        i_hold,
	output logic             o_tx_valid,
	output logic      [15:0] o_tx_word,
	output logic             o_rx_ack
);
	logic [15:0] sendq[$];
	logic [15:0] gotq[$];
	logic        taken;
	initial {o_tx_valid, o_tx_word, o_rx_ack, taken} <= '0;
	// Remember whether the offered word was accepted at this edge
	always @(posedge i_clk_sys)
		taken <= o_tx_valid & i_tx_ready;
	// Word stands until accepted; an idle bus shows the inverse so stale data never matches
	always @(negedge i_clk_sys)
	begin
		if (taken | !o_tx_valid)
		begin
			o_tx_valid <= sendq.size() != 0;
			if (sendq.size() != 0)
				o_tx_word <= sendq.pop_front();
			else
				o_tx_word <= ~o_tx_word;
		end
		// One-cycle acknowledge per word; a stalled host leaves the pair full
		if (o_rx_ack)
			o_rx_ack <= 1'b0;
		else if (i_rx_full & !i_hold)
		begin
			gotq.push_back(i_rx_word);
			o_rx_ack <= 1'b1;
		end
	end
endmodule

// ==== tb/host_port_core_side_regs_test.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) \
	begin mismatches++; $display("[ERR] %s exp=%h got=%h", n, e, g); end end
// ==========================================
// Bench top
module host_port_core_side_regs_test;
	import hpc_pkg::*;
	logic        clk = '0, rst_n = '0, swr = '0, stpr = '0, wr = '0, rd = '0, cs = '0, cmd = '0, cack = '0;
	logic        hold = 1'b1;
	logic [1:0]  hmode = 2'h2;
	logic [15:0] addr = '0, wd = '0, pin = '0, huse = '0, rdata, pout, poe, hrw, tw, d, v, r, w;
	logic [10:0] ha = '0;
	logic [1:0]  hf = '0;
	logic [7:0]  b;
	logic        rxi, txi, sel, tv, tr, pend, hrf, ack;
	logic [15:0] exp_q[$];
	int          mismatches = 0, n_compared = 0;

	hpc_core hpc_core_i (.i_clk_sys(clk), .i_arst_n(rst_n), .i_sw_reset(swr), .i_stop_reset(stpr),
		.i_core_addr(addr), .i_core_wr(wr), .i_core_rd(rd), .i_core_wdata(wd), .o_core_rdata(rdata),
		.o_rx_irq(rxi), .o_tx_irq(txi), .i_pin_in(pin), .o_pin_out(pout), .o_pin_oe(poe),
		.i_pin_host_use(huse), .i_host_addr(ha), .i_host_cs(cs), .o_host_sel(sel), .i_host_tx_valid(tv),
		.i_host_tx_word(tw), .o_host_tx_ready(tr), .o_host_tx_pending(pend), .o_host_rx_word(hrw),
		.o_host_rx_full(hrf), .i_host_rx_ack(ack), .i_host_cmd(cmd), .i_cmd_ack(cack), .i_host_flags(hf));
	hpc_host_model hpc_host_model_i (.i_clk_sys(clk), .i_tx_ready(tr), .i_rx_full(hrf), .i_rx_word(hrw),
		.i_hold(hold), .o_tx_valid(tv), .o_tx_word(tw), .o_rx_ack(ack));

	always #20 clk = ~clk;
	// Host stall: 0 acks freely, 1 stalls at random, 2 never acks
	always @(negedge clk)
		hold <= hmode[1] | (hmode[0] & 1'($urandom));

	// ==========================================
	// Core bus tasks, driven on the falling edge
	task automatic wreg(input logic [15:0] a, input logic [15:0] x);
		@(negedge clk);
		addr = a;
		wd = x;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	task automatic rreg(input logic [15:0] a);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		r = rdata;
	endtask
	task automatic rc(input logic [15:0] a, input logic [15:0] e);
		rreg(a);
		`CHK($sformatf("read %h", a), e, r)
	endtask
	// Bounded poll of one status bit
	task automatic wait_st(input int p);
		int n;
		n = 0;
		rreg(HPC_ADDR_STAT);
		while (r[p] !== 1'b1 && n < 60)
		begin
			rreg(HPC_ADDR_STAT);
			n++;
		end
		`CHK("status wait", 1'b1, r[p])
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
	endtask
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Watchdog: the sequence needs well under 8000 cycles
	initial
	begin
		#320000;
		mismatches++;
		test_done();
	end

	// ==========================================
	// Main sequence
	initial
	begin
		void'($urandom(32'h2badc2f0));
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		rc(HPC_ADDR_CTRL, 16'h0000);
		rc(HPC_ADDR_PCTRL, 16'h0000);
		rc(HPC_ADDR_BASE, 16'h0080);
		rc(HPC_ADDR_DIR, 16'h0000);
		rc(HPC_ADDR_STAT, 16'h0002);
		$display("reset values done");
		// Port disabled: every pin is plain I/O whatever the host claims
		repeat (4)
		begin
			d = $urandom;
			v = $urandom;
			pin = $urandom;
			huse = $urandom;
			wreg(HPC_ADDR_DIR, d);
			wreg(HPC_ADDR_VAL, v);
			@(negedge clk);
			`CHK("oe", d, poe)
			`CHK("out", d & v, pout & d)
			rc(HPC_ADDR_VAL, (d & v) | (~d & pin));
		end
		// Port enabled: claimed input pins read zero, claimed outputs keep what was written
		wreg(HPC_ADDR_PCTRL, 16'h0040);
		v = $urandom;
		wreg(HPC_ADDR_VAL, v);
		@(negedge clk);
		`CHK("gpio oe", d & ~huse, poe & ~huse)
		rc(HPC_ADDR_VAL, (d & v) | (~d & pin & ~huse));
		$display("pin control done");
		// Base match: low three bits ignored, each of bits 10..3 must break the match
		b = $urandom;
		wreg(HPC_ADDR_BASE, {8'hff, b});
		rc(HPC_ADDR_BASE, {8'h00, b});
		wreg(HPC_ADDR_PCTRL, 16'h0840);
		for (int i = 2; i < 11; i++)
		begin
			ha = {b, 3'h5} ^ (11'h001 << i);
			repeat (2) @(negedge clk);
			`CHK("sel", i < 3, sel)
		end
		wreg(HPC_ADDR_PCTRL, 16'h0040);
		cs = 1'b1;
		repeat (2) @(negedge clk);
		`CHK("sel cs", 1'b1, sel)
		cs = 1'b0;
		repeat (2) @(negedge clk);
		`CHK("sel cs off", 1'b0, sel)
		$display("chip select done");
		// Host to core: overfill the buffer, then drain it through the receive word
		wreg(HPC_ADDR_CTRL, 16'h0001);
		repeat (20)
		begin
			w = $urandom;
			exp_q.push_back(w);
			hpc_host_model_i.sendq.push_back(w);
		end
		repeat (60) @(negedge clk);
		`CHK("tx ready", 1'b0, tr)
		`CHK("pending", 1'b1, pend)
		`CHK("rx irq", 1'b1, rxi)
		while (exp_q.size() != 0)
		begin
			wait_st(HPC_STAT_RXF);
			rc(HPC_ADDR_RX, exp_q.pop_front());
		end
		rc(HPC_ADDR_STAT, 16'h0002);
		`CHK("rx irq off", 1'b0, rxi)
		hf = 2'h3;
		pulse(cmd);
		rc(HPC_ADDR_STAT, 16'h001e);
		pulse(cack);
		hf = 2'h0;
		$display("host to core done");
		// Core to host with the host stalled, then stalling at random
		wreg(HPC_ADDR_CTRL, 16'h0002);
		w = $urandom;
		exp_q.push_back(w);
		wreg(HPC_ADDR_TX, w);
		repeat (2) @(negedge clk);
		`CHK("host rx", w, hrw)
		`CHK("host full", 1'b1, hrf)
		`CHK("tx irq", 1'b1, txi)
		w = $urandom;
		exp_q.push_back(w);
		wreg(HPC_ADDR_TX, w);
		rc(HPC_ADDR_STAT, 16'h0000);
		`CHK("tx irq off", 1'b0, txi)
		rc(HPC_ADDR_TX, 16'h0000);
		hmode = 2'h1;
		repeat (6)
		begin
			wait_st(HPC_STAT_TXE);
			w = $urandom;
			exp_q.push_back(w);
			wreg(HPC_ADDR_TX, w);
		end
		hmode = 2'h0;
		repeat (20) @(negedge clk);
		while (exp_q.size() != 0)
		begin
			w = exp_q.pop_front();
			r = hpc_host_model_i.gotq.size() != 0 ? hpc_host_model_i.gotq.pop_front() : ~w;
			`CHK("host got", w, r)
		end
		$display("core to host done");
		// Clearing the enable empties both paths but keeps the configuration
		hmode = 2'h2;
		repeat (2) hpc_host_model_i.sendq.push_back(16'($urandom));
		wreg(HPC_ADDR_TX, 16'h5a5a);
		wreg(HPC_ADDR_TX, 16'ha5a5);
		repeat (10) @(negedge clk);
		wreg(HPC_ADDR_PCTRL, 16'h0000);
		rc(HPC_ADDR_STAT, 16'h0002);
		rc(HPC_ADDR_RX, 16'h0000);
		rc(HPC_ADDR_DIR, d);
		rc(HPC_ADDR_BASE, {8'h00, b});
		rc(HPC_ADDR_CTRL, 16'h0002);
		`CHK("host full clr", 1'b0, hrf)
		`CHK("pending clr", 1'b0, pend)
		$display("individual reset done");
		// Stop reset clears flags and data only; software reset restores every default except the pin value
		wreg(HPC_ADDR_PCTRL, 16'h0040);
		hpc_host_model_i.sendq.push_back(16'h0f0f);
		wait_st(HPC_STAT_RXF);
		pulse(stpr);
		rc(HPC_ADDR_STAT, 16'h0002);
		rc(HPC_ADDR_PCTRL, 16'h0040);
		rc(HPC_ADDR_DIR, d);
		rc(HPC_ADDR_RX, 16'h0000);
		pulse(swr);
		rc(HPC_ADDR_CTRL, 16'h0000);
		rc(HPC_ADDR_PCTRL, 16'h0000);
		rc(HPC_ADDR_BASE, 16'h0080);
		rc(HPC_ADDR_DIR, 16'h0000);
		rc(HPC_ADDR_STAT, 16'h0002);
		rc(HPC_ADDR_VAL, pin);
		$display("resets done");
		test_done();
	end
endmodule
